// >>> logic/ssp_cfg.svh
// Constants of the serial programming port
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_CNT_FULL 5'h10
`define SSP_CNT_SHORT_MAX 5'h0C
`define SSP_CNT_SAT 5'h1F
`define SSP_A_MAIN_IDX 4'h0
`define SSP_A_MAIN_MSB 4'h1
`define SSP_A_MAIN_LSB 4'h2
`define SSP_A_AUX_IDX 4'h3
`define SSP_A_AUX_FRAC 4'h4
`define SSP_A_CFG_BASE 4'h5
`define SSP_A_MOD_DATA 4'h9
`define SSP_NUM_CFG 4
`define SSP_IDX_RESET 9'h006
// Idle levels of feedback, select, data and serial clock, in that order
`define SSP_SYNC_IDLE 4'hE
`define SSP_IDX_FRAC_MIN 9'h006
`define SSP_IDX_FRAC_MAX 9'h1F9
`define SSP_FIFO_DEPTH 16
`define SSP_FIFO_WIDTH 17
`endif

// >>> logic/ssp_pkg.sv
// Types of the serial programming port
package ssp_pkg;
    // One decoded load travelling through the FIFO
    typedef struct packed {
        logic is_mod;
        logic [3:0] addr;
        logic [11:0] data;
    } ssp_load_t;
    // Active main ratio
    typedef struct packed {
        logic [8:0] idx;
        logic signed [17:0] frac;
    } ssp_main_t;
    // Active auxiliary ratio
    typedef struct packed {
        logic [8:0] idx;
        logic signed [9:0] frac;
    } ssp_aux_t;
    // Drain states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_FB = 2'b01
    } ssp_state_t;
endpackage : ssp_pkg

// >>> logic/ssp_fifo.sv
// Load FIFO with registered read data
`timescale 1ns/10ps
`default_nettype none
module ssp_fifo #(
    parameter int W = 17,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];          // Storage
    logic [AW-1:0] wptr_r;          // Write pointer
    logic [AW-1:0] rptr_r;          // Read pointer
    logic [AW:0] cnt_r;             // Words held in memory
    logic push;
    logic load;

    // Full is honest: count of stored words reaches depth
    assign in_ready = (cnt_r != (AW+1)'(D));
    assign push = in_valid && in_ready;
    // Refill the output register when it is empty or being taken
    assign load = (cnt_r != '0) && (!out_valid || out_ready);

    // Memory write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (load) begin
                rptr_r <= rptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data <= mem[rptr_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : ssp_fifo
`default_nettype wire

// >>> logic/ssp_top.sv
// Serial programming port: sampling, decode, load FIFO, register commit
// How it works
// - Shift data in on rising clock, select low
// - Echo stream on mux output at falling edges
// - Long frames keep only last sixteen bits
// - One to twelve edges: modulation sample, no address
// - Divider index nine bits, fractional range checked
// - Modulus 262144 or 1024 by mode
// - 18-bit offset is signed two's complement
// - 10-bit offset is signed
// - 18-bit word is upper ten, lower eight
// - Main 18-bit commits on upper write
// - Main 10-bit commits on upper write
// - Auxiliary commits on its fractional write
// - Integer mode commits on index write
// - Modulation offset added to main carrier
// - Four address bits then twelve data
// - Reset clears all but the pin synchronisers, which take idle levels, and the FIFO storage; indices become six
// - Resync; modulation waits feedback falling edge
`timescale 1ns/10ps
`default_nettype none
`include "ssp_cfg.svh"
module ssp_top (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SCLK_PIN,
    input wire logic SDATA_PIN,
    input wire logic CS_N_PIN,
    input wire logic DIVIDED_PRIMARY_FEEDBACK,
    input wire logic MODE_18BIT,
    input wire logic INTEGER_MODE,
    input wire logic MUX_SEL_SERIAL,
    output logic MUX_OUT,
    output ssp_pkg::ssp_main_t MAIN_RATIO,
    output ssp_pkg::ssp_aux_t AUX_RATIO,
    output logic [11:0] MOD_OFFSET,
    output logic [19:0] MAIN_TUNE,
    output logic MAIN_COMMIT,
    output logic AUX_COMMIT,
    output logic IDX_ILLEGAL,
    output logic LOAD_READY,
    output logic LOAD_DROPPED,
    output logic [`SSP_NUM_CFG-1:0][11:0] CFG_WORDS
);
    // Sign-extend a short sample of n bits to twelve bits
    function automatic logic [11:0] sext_n(input logic [15:0] v, input logic [4:0] n);
        logic [11:0] r;
        r = v[11:0];
        for (int i = 1; i < 12; i++) begin
            if (5'(i) >= n) begin
                r[i] = v[n-1];
            end
        end
        return r;
    endfunction : sext_n

    // Pin synchronisers: sclk, data, select, feedback
    logic [3:0] pin_in;
    logic [3:0] s1_r;               // First stage, read only by second
    logic [3:0] s2_r;               // Second stage
    logic [3:0] s3_r;               // Delayed copy for edge detection
    assign pin_in = {DIVIDED_PRIMARY_FEEDBACK, CS_N_PIN, SDATA_PIN, SCLK_PIN};

    // Three flops per pin, all resynchronised to the reference clock
    // Reset to each pin's idle level, so no false edge follows reset
    localparam logic [3:0] sync_idle = `SSP_SYNC_IDLE;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    s1_r[g] <= sync_idle[g];
                    s2_r[g] <= sync_idle[g];
                    s3_r[g] <= sync_idle[g];
                end else begin
                    s1_r[g] <= pin_in[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                end
            end
        end
    endgenerate

    logic sdata_s;
    logic cs_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic fb_fall;
    assign sdata_s = s2_r[1];
    assign cs_s = s2_r[2];
    assign sclk_rise = s2_r[0] && !s3_r[0];
    assign sclk_fall = !s2_r[0] && s3_r[0];
    assign cs_rise = s2_r[2] && !s3_r[2];
    assign fb_fall = !s2_r[3] && s3_r[3];

    // Shift register and edge count of the current frame
    logic [15:0] shift_r;
    logic [4:0] cnt_r;              // Saturates at 31; counts 1 to 12 and 16 and above matter
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            shift_r <= '0;
            cnt_r <= '0;
        end else if (cs_s) begin
            cnt_r <= '0;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[14:0], sdata_s};
            if (cnt_r != `SSP_CNT_SAT) begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // Loopback: last captured bit leaves on the falling clock edge
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            MUX_OUT <= 1'b0;
        end else if (!MUX_SEL_SERIAL) begin
            MUX_OUT <= 1'b0;            // Other mux sources live elsewhere
        end else if (sclk_fall && !cs_s) begin
            MUX_OUT <= shift_r[0];
        end
    end

    // Frame decode at the rising edge of select
    ssp_pkg::ssp_load_t push_data_r;
    logic push_valid_r;
    logic fifo_in_ready;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            push_valid_r <= 1'b0;
            push_data_r <= '0;
        end else begin
            push_valid_r <= 1'b0;
            if (cs_rise && cnt_r >= `SSP_CNT_FULL) begin
                // Only the last sixteen bits remain in the shifter
                push_valid_r <= 1'b1;
                push_data_r.addr <= shift_r[15:12];
                push_data_r.data <= shift_r[11:0];
                push_data_r.is_mod <= (shift_r[15:12] == `SSP_A_MOD_DATA);
            end else if (cs_rise && cnt_r != 5'h00 && cnt_r <= `SSP_CNT_SHORT_MAX) begin
                push_valid_r <= 1'b1;
                push_data_r.addr <= `SSP_A_MOD_DATA;
                push_data_r.data <= sext_n(shift_r, cnt_r);
                push_data_r.is_mod <= 1'b1;
            end
        end
    end

    // Back-pressure seen by the frame side
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            LOAD_READY <= 1'b0;
            LOAD_DROPPED <= 1'b0;
        end else begin
            LOAD_READY <= fifo_in_ready;
            LOAD_DROPPED <= push_valid_r && !fifo_in_ready;
        end
    end

    // Load FIFO between the serial side and the commit side
    logic fifo_out_valid;
    logic pop;
    ssp_pkg::ssp_load_t pop_data;
    ssp_fifo #(
        .W(`SSP_FIFO_WIDTH),
        .D(`SSP_FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst(RST),
        .in_valid(push_valid_r),
        .in_ready(fifo_in_ready),
        .in_data(push_data_r),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(pop_data)
    );

    // Drain state: modulation samples stall until feedback falls
    ssp_pkg::ssp_state_t state_r;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_r <= ssp_pkg::ST_IDLE;
        end else begin
            case (state_r)
                ssp_pkg::ST_IDLE: begin
                    if (fifo_out_valid && pop_data.is_mod) begin
                        state_r <= ssp_pkg::ST_WAIT_FB;
                    end
                end
                ssp_pkg::ST_WAIT_FB: begin
                    if (fb_fall) begin
                        state_r <= ssp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ssp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Register writes pop at once; samples only on the feedback edge
    assign pop = fifo_out_valid && ((state_r == ssp_pkg::ST_IDLE && !pop_data.is_mod)
                 || (state_r == ssp_pkg::ST_WAIT_FB && fb_fall));

    logic wr;
    assign wr = pop && !pop_data.is_mod;

    // Staging registers; they never touch the active ratio directly
    logic [8:0] main_idx_stg_r;
    logic [7:0] main_lsb_stg_r;
    logic [8:0] aux_idx_stg_r;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            main_idx_stg_r <= `SSP_IDX_RESET;
            main_lsb_stg_r <= '0;
            aux_idx_stg_r <= `SSP_IDX_RESET;
        end else if (wr) begin
            case (pop_data.addr)
                `SSP_A_MAIN_IDX: main_idx_stg_r <= pop_data.data[8:0];
                `SSP_A_MAIN_LSB: main_lsb_stg_r <= pop_data.data[7:0];
                `SSP_A_AUX_IDX: aux_idx_stg_r <= pop_data.data[8:0];
                default: begin
                end
            endcase
        end
    end

    // Active main ratio, changed only by committing writes
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            MAIN_RATIO.idx <= `SSP_IDX_RESET;
            MAIN_RATIO.frac <= '0;
            MAIN_COMMIT <= 1'b0;
        end else begin
            MAIN_COMMIT <= 1'b0;
            if (wr && pop_data.addr == `SSP_A_MAIN_IDX && INTEGER_MODE) begin
                MAIN_RATIO.idx <= pop_data.data[8:0];
                MAIN_COMMIT <= 1'b1;
            end else if (wr && pop_data.addr == `SSP_A_MAIN_MSB) begin
                MAIN_RATIO.idx <= main_idx_stg_r;
                MAIN_COMMIT <= 1'b1;
                if (MODE_18BIT) begin
                    // Modulus 2^18: upper ten and lower eight bits
                    MAIN_RATIO.frac <= {pop_data.data[9:0], main_lsb_stg_r};
                end else begin
                    // Modulus 2^10: ten signed bits, sign extended
                    MAIN_RATIO.frac <= {{8{pop_data.data[9]}}, pop_data.data[9:0]};
                end
            end
        end
    end

    // Active auxiliary ratio
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            AUX_RATIO.idx <= `SSP_IDX_RESET;
            AUX_RATIO.frac <= '0;
            AUX_COMMIT <= 1'b0;
        end else begin
            AUX_COMMIT <= 1'b0;
            if (wr && pop_data.addr == `SSP_A_AUX_IDX && INTEGER_MODE) begin
                AUX_RATIO.idx <= pop_data.data[8:0];
                AUX_COMMIT <= 1'b1;
            end else if (wr && pop_data.addr == `SSP_A_AUX_FRAC) begin
                AUX_RATIO.idx <= aux_idx_stg_r;
                AUX_RATIO.frac <= pop_data.data[9:0];
                AUX_COMMIT <= 1'b1;
            end
        end
    end

    // Remaining configuration words, stored as written
    generate
        for (g = 0; g < `SSP_NUM_CFG; g++) begin : g_cfg
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    CFG_WORDS[g] <= '0;
                end else if (wr && pop_data.addr == `SSP_A_CFG_BASE + 4'(g)) begin
                    CFG_WORDS[g] <= pop_data.data;
                end
            end
        end
    endgenerate

    // Modulation data passes onward on the feedback falling edge
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            MOD_OFFSET <= '0;
        end else if (pop && pop_data.is_mod) begin
            MOD_OFFSET <= pop_data.data;
        end
    end

    // Carrier plus instantaneous offset; index range flag
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            MAIN_TUNE <= '0;
            IDX_ILLEGAL <= 1'b0;
        end else begin
            MAIN_TUNE <= {{2{MAIN_RATIO.frac[17]}}, MAIN_RATIO.frac}
                         + {{8{MOD_OFFSET[11]}}, MOD_OFFSET};
            // Integer mode accepts every nine-bit value
            IDX_ILLEGAL <= !INTEGER_MODE && (MAIN_RATIO.idx < `SSP_IDX_FRAC_MIN
                           || MAIN_RATIO.idx > `SSP_IDX_FRAC_MAX);
        end
    end

    // Checks on the port's own behaviour
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    a_shift_capture: assert property (sclk_rise && !cs_s |=>
        shift_r == {$past(shift_r[14:0]), $past(sdata_s)})
        else $error("serial bit not captured");
    a_idle_hold: assert property (cs_s |=> $stable(shift_r))
        else $error("shifter moved while deselected");
    a_mux_echo: assert property (MUX_SEL_SERIAL && sclk_fall && !cs_s |=>
        MUX_OUT == $past(shift_r[0]))
        else $error("mux output missed falling edge");
    a_full_word: assert property (cs_rise && cnt_r >= 5'h10 |=>
        push_valid_r && push_data_r.data == $past(shift_r[11:0])
        && push_data_r.addr == $past(shift_r[15:12]))
        else $error("long frame decoded wrongly");
    a_short_mod: assert property (cs_rise && cnt_r != 5'h00 && cnt_r < 5'h0D |=>
        push_valid_r && push_data_r.is_mod)
        else $error("short frame not modulation");
    a_reset_idx: assert property (disable iff (1'b0) RST |=>
        MAIN_RATIO.idx == 9'h006 && AUX_RATIO.idx == 9'h006 && MOD_OFFSET == 12'h000)
        else $error("reset values wrong");
    a_stage_hold: assert property (wr && !INTEGER_MODE && pop_data.addr != 4'h1 |=>
        $stable(MAIN_RATIO))
        else $error("staged write changed ratio");
    a_int_commit: assert property (wr && INTEGER_MODE && pop_data.addr == 4'h0 |=>
        MAIN_RATIO.idx == $past(pop_data.data[8:0]) && MAIN_COMMIT)
        else $error("integer index not applied");
    a_frac18_join: assert property (wr && MODE_18BIT && pop_data.addr == 4'h1 |=>
        MAIN_RATIO.frac == {$past(pop_data.data[9:0]), $past(main_lsb_stg_r)}
        && MAIN_RATIO.idx == $past(main_idx_stg_r))
        else $error("18-bit word not assembled");
    a_aux_commit: assert property (wr && pop_data.addr == 4'h4 |=>
        AUX_RATIO.idx == $past(aux_idx_stg_r) && AUX_COMMIT)
        else $error("auxiliary ratio not applied");
    a_mod_wait: assert property (state_r == ssp_pkg::ST_WAIT_FB && !fb_fall |=>
        $stable(MOD_OFFSET))
        else $error("modulation passed before feedback edge");
    a_tune_sum: assert property (1'b1 |=>
        MAIN_TUNE == 20'($signed($past(MAIN_RATIO.frac))) + 20'($signed($past(MOD_OFFSET))))
        else $error("tune word drifted");

    c_full_load: cover property (wr && pop_data.addr == 4'h1);
    c_short_mod: cover property (pop && pop_data.is_mod);
    c_fifo_full: cover property (!fifo_in_ready);
    c_int_commit: cover property (MAIN_COMMIT && INTEGER_MODE);
endmodule : ssp_top
`default_nettype wire

// >>> verification/ssp_host.sv
// Host model that drives the three serial programming lines
`timescale 1ns/10ps
`default_nettype none
module ssp_host (
    input wire logic CLOCK,
    input wire logic MUX_OUT,
    output var logic SCLK_PIN,
    output var logic SDATA_PIN,
    output var logic CS_N_PIN
);
    logic [31:0] echo_r; // Mux output seen after each bit, newest in bit 0

    // Serial clock stands still low between frames
    initial begin
        SCLK_PIN = 1'b0;
        SDATA_PIN = 1'b0;
        CS_N_PIN = 1'b1;
        echo_r = 32'h0;
    end

    // Four reference cycles per level; the port needs at least three
    task automatic hold4();
        repeat (4) @(posedge CLOCK);
        #2;
    endtask : hold4

    // One frame of n bits, most significant first, select low throughout
    task automatic send(input logic [31:0] w, input int n);
        CS_N_PIN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            SDATA_PIN = w[i];
            hold4();
            SCLK_PIN = 1'b1;
            hold4();
            SCLK_PIN = 1'b0;
            hold4();
            echo_r = {echo_r[30:0], MUX_OUT};
        end
        CS_N_PIN = 1'b1;
        // Released line shows the inverse, never a stale bit
        SDATA_PIN = ~SDATA_PIN;
        hold4();
    endtask : send

    // Stray clocks with select high; only ordered on purpose by the bench
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            SDATA_PIN = ~SDATA_PIN;
            SCLK_PIN = 1'b1;
            hold4();
            SCLK_PIN = 1'b0;
            hold4();
        end
    endtask : stray
endmodule : ssp_host
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the serial programming port
`timescale 1ns/10ps
`default_nettype none
`include "ssp_cfg.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fb = 1'b1; // Divided feedback, toggled only while fb_run is set
    logic fb_run = 1'b0;
    logic mode18 = 1'b0;
    logic int_mode = 1'b0;
    logic mux_sel = 1'b1;
    wire logic sclk;
    wire logic sdata;
    wire logic cs_n;
    logic mux_out;
    ssp_pkg::ssp_main_t main_ratio;
    ssp_pkg::ssp_aux_t aux_ratio;
    logic [11:0] mod_off;
    logic [19:0] tune;
    logic main_c;
    logic aux_c;
    logic illegal;
    logic ready;
    logic dropped;
    logic [`SSP_NUM_CFG-1:0][11:0] cfg;
    // Running counts of one-cycle pulses and of cycles with ready low; the sequence compares deltas
    int main_cnt = 0;
    int aux_cnt = 0;
    int drop_cnt = 0;
    int full_cnt = 0;
    int main_base = 0; // Main and auxiliary counts taken at the start of the last write
    int aux_base = 0;
    int drop_base = 0;
    int full_base = 0;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;

    ssp_top dut_u (.CLOCK(clk), .RST(rst), .SCLK_PIN(sclk), .SDATA_PIN(sdata),
        .CS_N_PIN(cs_n), .DIVIDED_PRIMARY_FEEDBACK(fb), .MODE_18BIT(mode18),
        .INTEGER_MODE(int_mode), .MUX_SEL_SERIAL(mux_sel), .MUX_OUT(mux_out),
        .MAIN_RATIO(main_ratio), .AUX_RATIO(aux_ratio), .MOD_OFFSET(mod_off),
        .MAIN_TUNE(tune), .MAIN_COMMIT(main_c), .AUX_COMMIT(aux_c),
        .IDX_ILLEGAL(illegal), .LOAD_READY(ready), .LOAD_DROPPED(dropped),
        .CFG_WORDS(cfg));

    ssp_host host_u (.CLOCK(clk), .MUX_OUT(mux_out), .SCLK_PIN(sclk),
        .SDATA_PIN(sdata), .CS_N_PIN(cs_n));

    // 40 MHz reference clock
    always #12.5 clk = ~clk;

    // Feedback divider, pulse recorders and the hang limit
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (fb_run && cycles % 5 == 0) begin
            fb <= #2 ~fb;
        end
        if (main_c === 1'b1) begin
            main_cnt <= main_cnt + 1;
        end
        if (aux_c === 1'b1) begin
            aux_cnt <= aux_cnt + 1;
        end
        if (dropped === 1'b1) begin
            drop_cnt <= drop_cnt + 1;
        end
        if (ready === 1'b0) begin
            full_cnt <= full_cnt + 1;
        end
        // Ceiling well above the roughly 8200 cycles the sequence needs
        if (cycles == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask : chk_flag

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : settle

    // Full register write; the commit lands a few cycles after select rises
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        main_base = main_cnt;
        aux_base = aux_cnt;
        host_u.send({16'h0, a, d}, 16);
        settle(12);
    endtask : wr

    task automatic main_is(input logic [8:0] idx, input logic [17:0] frac);
        chk_val({5'h0, main_ratio}, {5'h0, idx, frac});
    endtask : main_is

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        settle(20);
        rst = 1'b0;
        settle(4);
        main_is(`SSP_IDX_RESET, 18'h0);
        chk_val({13'h0, aux_ratio}, {13'h0, `SSP_IDX_RESET, 10'h0});
        chk_val({8'h0, cfg[1], cfg[0]}, 32'h0);
        chk_val({8'h0, cfg[3], cfg[2]}, 32'h0);
        chk_val({20'h0, mod_off}, 32'h0);
        // Main ratio in 10-bit mode: index staged, dividend commits
        wr(`SSP_A_MAIN_IDX, 12'h010);
        main_is(`SSP_IDX_RESET, 18'h0);
        chk_val(main_cnt - main_base, 0);
        wr(`SSP_A_MAIN_MSB, 12'h334);
        main_is(9'h010, 18'h3FF34);
        chk_val(main_cnt - main_base, 1);
        // Auxiliary ratio commits on its dividend only
        wr(`SSP_A_AUX_IDX, 12'h012);
        chk_val({13'h0, aux_ratio}, {13'h0, `SSP_IDX_RESET, 10'h0});
        chk_val(aux_cnt - aux_base, 0);
        wr(`SSP_A_AUX_FRAC, 12'h1FF);
        chk_val({13'h0, aux_ratio}, {13'h0, 9'h012, 10'h1FF});
        chk_val(aux_cnt - aux_base, 1);
        // Main ratio in 18-bit mode: low part staged, upper part commits
        mode18 = 1'b1;
        wr(`SSP_A_MAIN_IDX, 12'h00D);
        wr(`SSP_A_MAIN_LSB, 12'h098);
        main_is(9'h010, 18'h3FF34);
        wr(`SSP_A_MAIN_MSB, 12'h07D);
        main_is(9'h00D, 18'h07D98);
        chk_val({12'h0, tune}, 32'h07D98);
        chk_flag(illegal, 1'b0);
        chk_val({16'h0, host_u.echo_r[15:0]}, 32'h107D);
        // Echo stops when the mux shows another source
        mux_sel = 1'b0;
        settle(2);
        chk_flag(mux_out, 1'b0);
        mux_sel = 1'b1;
        // Short frames are modulation samples, sign-extended
        fb_run = 1'b1;
        host_u.send(32'hA5C, 12);
        settle(40);
        chk_val({20'h0, mod_off}, 32'hA5C);
        chk_val({12'h0, tune}, 32'h077F4);
        host_u.send(32'h16, 5);
        settle(40);
        chk_val({20'h0, mod_off}, 32'hFF6);
        chk_val({12'h0, tune}, 32'h07D8E);
        // Thirteen bits, a reserved address and stray clocks change nothing
        host_u.send(32'h1FFF, 13);
        wr(4'hA, 12'hFFF);
        host_u.stray(8);
        settle(40);
        chk_val({20'h0, mod_off}, 32'hFF6);
        chk_val({8'h0, cfg[1], cfg[0]}, 32'h0);
        // Stray bits must not lengthen this twelve-bit frame
        host_u.send(32'h5A5, 12);
        settle(40);
        chk_val({20'h0, mod_off}, 32'h5A5);
        // Long frame keeps only its last sixteen bits
        host_u.send(32'h45ABC, 20);
        settle(16);
        chk_val({20'h0, cfg[0]}, 32'hABC);
        chk_val({13'h0, aux_ratio}, {13'h0, 9'h012, 10'h1FF});
        for (int a = 6; a <= 8; a++) begin
            wr(a[3:0], {8'h10, a[3:0]});
            chk_val({20'h0, cfg[a - 5]}, {20'h0, 8'h10, a[3:0]});
        end
        wr(`SSP_A_MOD_DATA, 12'h7FF);
        settle(30);
        chk_val({20'h0, mod_off}, 32'h7FF);
        // Integer mode: index writes commit at once, main and auxiliary
        int_mode = 1'b1;
        wr(`SSP_A_MAIN_IDX, 12'h1FF);
        main_is(9'h1FF, 18'h07D98);
        chk_val(main_cnt - main_base, 1);
        wr(`SSP_A_AUX_IDX, 12'h020);
        chk_val({13'h0, aux_ratio}, {13'h0, 9'h020, 10'h1FF});
        chk_val(aux_cnt - aux_base, 1);
        int_mode = 1'b0;
        settle(4);
        chk_flag(illegal, 1'b1);
        int_mode = 1'b1;
        wr(`SSP_A_MAIN_IDX, {3'h0, `SSP_IDX_FRAC_MAX});
        int_mode = 1'b0;
        settle(4);
        chk_flag(illegal, 1'b0);
        // Held feedback blocks a sample; sixteen writes fill the queue, two drop
        fb_run = 1'b0;
        full_base = full_cnt;
        drop_base = drop_cnt;
        host_u.send(32'h123, 12);
        for (int k = 0; k < 18; k++) begin
            host_u.send({16'h0, `SSP_A_CFG_BASE + 4'h1, 4'h0, k[7:0]}, 16);
        end
        settle(10);
        chk_val({20'h0, mod_off}, 32'h7FF);
        chk_flag(full_cnt != full_base, 1'b1);
        chk_val(drop_cnt - drop_base, 2);
        fb_run = 1'b1;
        settle(300);
        chk_val({20'h0, mod_off}, 32'h123);
        chk_val({20'h0, cfg[1]}, 32'h00F);
        chk_flag(ready, 1'b1);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
